// ### rtl/fcu_pkg.sv
// package for the fieldbus character uart
// assumes a 40 MHz system clock and an 11-bit character frame
package fcu_pkg;

	// ==========================================
	// timing constants
	localparam int unsigned CLK_HZ        = 40_000_000; // system clock rate
	localparam int unsigned OVERSAMPLE    = 4;          // samples per bit
	localparam int unsigned DIV_W         = 16;         // divisor width
	localparam logic [15:0] DIV_RESET     = 16'h0000;   // divisor at reset

	// ==========================================
	// frame layout
	localparam int unsigned DATA_BITS     = 8;    // data bits per char
	localparam int unsigned FRAME_BITS    = 11;   // start+8+parity+stop
	localparam logic [3:0]  PAR_IDX       = 4'h9; // parity position
	localparam logic [3:0]  STOP_IDX      = 4'ha; // stop position
	localparam logic [1:0]  MID_PHASE     = 2'h2; // mid-bit sample phase
	localparam logic [1:0]  RELAX_PHASE   = 2'h1; // early stop sample phase
	localparam logic [1:0]  LAST_PHASE    = 2'h3; // last sub-bit phase

	// ==========================================
	// state encodings
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_WAIT = 2'b01,
		TX_SEND = 2'b11,
		TX_GAP  = 2'b10
	} fcu_tx_state_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11
	} fcu_rx_state_t;

	// ==========================================
	// carriers
	typedef struct packed {
		logic       valid; // byte offered
		logic       last;  // final byte of telegram
		logic [7:0] data;  // byte value
	} fcu_tx_byte_t;

	typedef struct packed {
		logic       valid;      // one-cycle pulse
		logic       parity_err; // parity mismatch
		logic       stop_err;   // stop bit low
		logic [7:0] data;       // byte value
	} fcu_rx_byte_t;

	typedef struct packed {
		logic rts_out;  // request-to-send level
		logic rts_oe_n; // request-to-send enable, low drives
		logic txd_out;  // transmit data level
		logic txd_oe_n; // transmit data enable, low drives
	} fcu_line_out_t;

	// even parity of a byte
	function automatic logic fcu_parity(input logic [7:0] b);
		fcu_parity = ^b;
	endfunction

endpackage

// ### rtl/fcu_rx.sv
// four-fold oversampling character receiver
// assumes rxd is already synchronised and tick is a 4x bit-rate pulse
`timescale 1ns/100ps
`default_nettype none

module fcu_rx
(
	input  wire logic               sys_clk,
	input  wire logic               reset_n,
	input  wire logic               tick,
	input  wire logic               rxd,
	input  wire logic               stop_check_disable,
	input  wire logic               start_check_relax,
	output var  fcu_pkg::fcu_rx_byte_t rx_byte
);
	import fcu_pkg::*;

	// ==========================================
	// state
	typedef struct packed {
		fcu_rx_state_t st;       // receiver phase
		logic [1:0]    phase;    // sub-bit counter
		logic [3:0]    bit_idx;  // frame bit index
		logic [8:0]    shift;    // data plus parity
		logic          rxd_d;    // previous line level
		fcu_rx_byte_t  out;      // result
	} fcu_rx_s_t;

	fcu_rx_s_t s_reg;  // registered state
	fcu_rx_s_t s_next; // next state
	logic      sample; // sampling moment of current bit

	// ==========================================
	// next-state logic
	always_comb
	begin
		s_next = s_reg;
		s_next.out.valid = 1'b0;
		sample = 1'b0;
		if (tick)
		begin
			s_next.rxd_d = rxd;
			s_next.phase = s_reg.phase + 2'h1; // 4 sub-bits per bit
		end
		case (s_reg.st)
			RX_IDLE:
			begin
				// falling edge starts sync
				if (tick && s_reg.rxd_d && !rxd)
				begin
					s_next.st = RX_START;
					// start check lands two ticks after the edge
					s_next.phase = 2'h0;
				end
			end
			RX_START:
			begin
				if (tick && s_reg.phase == MID_PHASE - 2'h1)
				begin
					// mid start bit must still be low
					if (rxd)
						s_next.st = RX_IDLE; // glitch, rearm
					else
					begin
						s_next.st = RX_DATA;
						s_next.bit_idx = 4'h1;
					end
				end
			end
			RX_DATA:
			begin
				// relaxed mode samples stop early for distortion
				if (start_check_relax && s_reg.bit_idx == STOP_IDX)
					sample = tick && s_reg.phase == RELAX_PHASE - 2'h1;
				else
					sample = tick && s_reg.phase == MID_PHASE - 2'h1;
				if (sample)
				begin
					if (s_reg.bit_idx == STOP_IDX)
					begin
						// lsb first, even parity
						s_next.out.data = s_reg.shift[7:0];
						s_next.out.parity_err =
							fcu_parity(s_reg.shift[7:0]) != s_reg.shift[8];
						// stop check skipped when disabled
						s_next.out.stop_err = !stop_check_disable && !rxd;
						s_next.out.valid = 1'b1;
						s_next.st = RX_IDLE;
					end
					else
					begin
						s_next.shift = {rxd, s_reg.shift[8:1]};
						s_next.bit_idx = s_reg.bit_idx + 4'h1;
					end
				end
			end
			default: s_next.st = RX_IDLE;
		endcase
	end

	// ==========================================
	// state register
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			s_reg <= '{st: RX_IDLE, phase: 2'h0, bit_idx: 4'h0,
				shift: 9'h000, rxd_d: 1'b1, out: '0};
		else
			s_reg <= s_next;
	end

	assign rx_byte = s_reg.out;

endmodule

`default_nettype wire

// ### rtl/fcu_uart.sv
// top of the fieldbus character uart: transmitter plus receiver
// assumes an rs485 transceiver with pull-up on txd and a cts line
`timescale 1ns/100ps
`default_nettype none

module fcu_uart
(
	input  wire logic                  sys_clk,
	input  wire logic                  reset_n,
	input  wire logic [15:0]           bit_div,
	input  wire logic                  stop_check_disable,
	input  wire logic                  start_check_relax,
	input  wire fcu_pkg::fcu_tx_byte_t tx_byte,
	output logic                       tx_ready,
	output logic                       tx_busy,
	output fcu_pkg::fcu_rx_byte_t      rx_byte,
	input  wire logic                  rxd_pin,
	input  wire logic                  clear_to_send_in,
	input  wire logic                  output_float_test_pin,
	output fcu_pkg::fcu_line_out_t     line_out
);
	import fcu_pkg::*;

	// ==========================================
	// state
	typedef struct packed {
		logic [15:0]   div_cnt;  // 4x tick divider
		logic [1:0]    rxd_sy;   // rxd synchroniser
		logic [1:0]    cts_sy;   // cts synchroniser
		logic [1:0]    flt_sy;   // float pin synchroniser
		fcu_tx_state_t st;       // transmitter phase
		logic [1:0]    phase;    // sub-bit counter
		logic [3:0]    bit_idx;  // frame bit index
		logic [10:0]   frame;    // shift register of frame
		logic [7:0]    hold;     // next byte taken early
		logic          hold_v;   // hold is loaded
		logic          hold_last;// hold ends telegram
		logic          cur_last; // current char ends telegram
		logic          tx_ready; // output copy
		logic          tx_busy;  // output copy
		fcu_line_out_t line;     // pin drivers
	} fcu_top_s_t;

	fcu_top_s_t s_reg;  // registered state
	fcu_top_s_t s_next; // next state
	logic       tick;   // 4x bit-rate strobe
	logic       cts_ok; // synchronised cts, active low pin
	logic       bit_end;// last sub-bit of current bit
	logic       txd_lvl;// level wanted on txd

	// builds an 11-bit frame, lsb sent first
	function automatic logic [10:0] fcu_frame(input logic [7:0] b);
		fcu_frame = {1'b1, fcu_parity(b), b, 1'b0};
	endfunction

	// ==========================================
	// receiver
	fcu_rx u_rx
	(
		.sys_clk           (sys_clk),
		.reset_n           (reset_n),
		.tick              (tick),
		.rxd               (s_reg.rxd_sy[1]),
		.stop_check_disable(stop_check_disable),
		.start_check_relax (start_check_relax),
		.rx_byte           (rx_byte)
	);

	assign tick    = s_reg.div_cnt == 16'h0000;
	assign cts_ok  = !s_reg.cts_sy[1];
	assign bit_end = tick && s_reg.phase == LAST_PHASE;

	// ==========================================
	// next-state logic
	always_comb
	begin
		s_next = s_reg;
		txd_lvl = 1'b1;
		// divider reload gives four ticks per bit
		s_next.div_cnt = tick ? bit_div : s_reg.div_cnt - 16'h0001;
		s_next.rxd_sy = {s_reg.rxd_sy[0], rxd_pin};
		s_next.cts_sy = {s_reg.cts_sy[0], clear_to_send_in};
		s_next.flt_sy = {s_reg.flt_sy[0], output_float_test_pin};
		if (tick)
			s_next.phase = s_reg.phase + 2'h1;
		// take a byte into the hold stage when free
		if (tx_byte.valid && s_reg.tx_ready)
		begin
			s_next.hold = tx_byte.data;
			s_next.hold_v = 1'b1;
			s_next.hold_last = tx_byte.last;
		end
		case (s_reg.st)
			TX_IDLE:
			begin
				if (s_reg.hold_v)
				begin
					s_next.st = TX_WAIT; // rts before first char
					s_next.phase = 2'h0;
				end
			end
			TX_WAIT, TX_GAP:
			begin
				// character held while cts inactive
				if (cts_ok && s_reg.hold_v && tick)
				begin
					s_next.st = TX_SEND;
					s_next.frame = fcu_frame(s_reg.hold);
					s_next.cur_last = s_reg.hold_last;
					s_next.hold_v = 1'b0;
					s_next.bit_idx = 4'h0;
					// full four sub-bits for the start bit
					s_next.phase = 2'h0;
				end
			end
			TX_SEND:
			begin
				txd_lvl = s_reg.frame[0];
				if (bit_end)
				begin
					if (s_reg.bit_idx == STOP_IDX)
					begin
						if (s_reg.cur_last)
							s_next.st = TX_IDLE;
						else if (s_reg.hold_v && cts_ok)
						begin
							// next char follows stop at once
							s_next.frame = fcu_frame(s_reg.hold);
							s_next.cur_last = s_reg.hold_last;
							s_next.hold_v = 1'b0;
							s_next.bit_idx = 4'h0;
						end
						else
							s_next.st = TX_GAP;
					end
					else
					begin
						s_next.frame = {1'b1, s_reg.frame[10:1]};
						s_next.bit_idx = s_reg.bit_idx + 4'h1;
					end
				end
			end
			default: s_next.st = TX_IDLE;
		endcase
		s_next.tx_ready = !s_next.hold_v;
		s_next.tx_busy = s_next.st != TX_IDLE;
		// pins float in test mode txd floats unless sending
		s_next.line.rts_out = s_next.st != TX_IDLE;
		s_next.line.rts_oe_n = !s_reg.flt_sy[1];
		s_next.line.txd_out = txd_lvl;
		s_next.line.txd_oe_n = !s_reg.flt_sy[1] || s_reg.st != TX_SEND;
	end

	// ==========================================
	// state register
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			s_reg <= '{div_cnt: DIV_RESET, rxd_sy: 2'b11, cts_sy: 2'b11,
				flt_sy: 2'b00, st: TX_IDLE, phase: 2'h0, bit_idx: 4'h0,
				frame: 11'h7ff, hold: 8'h00, hold_v: 1'b0,
				hold_last: 1'b0, cur_last: 1'b0, tx_ready: 1'b0,
				tx_busy: 1'b0, line: 4'b0101};
		else
			s_reg <= s_next;
	end

	assign tx_ready = s_reg.tx_ready;
	assign tx_busy  = s_reg.tx_busy;
	assign line_out = s_reg.line;

endmodule

`default_nettype wire

// ### testbench/fcu_uart_chk.sv
// assertions on the ports of the character uart top
// assumes it is bound onto every fcu_uart instance
`timescale 1ns/100ps
`default_nettype none

module fcu_uart_chk
	import fcu_pkg::*;
(
	input wire logic          sys_clk,
	input wire logic          reset_n,
	input wire fcu_tx_byte_t  tx_byte,
	input wire logic          tx_ready,
	input wire logic          tx_busy,
	input wire fcu_rx_byte_t  rx_byte,
	input wire logic          clear_to_send_in,
	input wire logic          output_float_test_pin,
	input wire fcu_line_out_t line_out
);
	// ==========================================
	// one clock domain, one reset
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	// ==========================================
	// transmit side
	chk_take_drop: assert property (
		tx_byte.valid && tx_ready |=> !tx_ready)
		else $error("tx_ready stayed high after a take");
	chk_busy_rise: assert property (
		tx_byte.valid && tx_ready && !tx_busy |-> ##2 tx_busy)
		else $error("telegram did not start two cycles after take");
	chk_rts_busy: assert property (
		tx_busy |-> line_out.rts_out)
		else $error("rts low inside a telegram");
	chk_start_low: assert property (
		$fell(line_out.txd_oe_n) |-> !line_out.txd_out && line_out.rts_out)
		else $error("frame began without low start bit or rts");
	chk_cts_block: assert property (
		clear_to_send_in [*8] |-> !$fell(line_out.txd_oe_n))
		else $error("character started while cts inactive");
	chk_txd_idle: assert property (
		!tx_busy [*2] |-> line_out.txd_oe_n)
		else $error("txd driven outside a telegram");
	chk_float_all: assert property (
		!output_float_test_pin [*4] |-> line_out.rts_oe_n && line_out.txd_oe_n)
		else $error("outputs driven in float test");

	// ==========================================
	// receive side
	chk_rx_pulse: assert property (
		rx_byte.valid |=> !rx_byte.valid)
		else $error("rx valid longer than one cycle");

	// main scenarios reached
	cov_rx: cover property (rx_byte.valid);
	cov_frame: cover property ($fell(line_out.txd_oe_n));
	cov_stop: cover property (rx_byte.valid && rx_byte.stop_err);
endmodule

bind fcu_uart fcu_uart_chk u_fcu_uart_chk
(
	.sys_clk               (sys_clk),
	.reset_n               (reset_n),
	.tx_byte               (tx_byte),
	.tx_ready              (tx_ready),
	.tx_busy               (tx_busy),
	.rx_byte               (rx_byte),
	.clear_to_send_in      (clear_to_send_in),
	.output_float_test_pin (output_float_test_pin),
	.line_out              (line_out)
);
`default_nettype wire

// ### testbench/fcu_modem.sv
// model of the isolated rs485 transceiver at the line side
// assumes a pull-up on the bus and a bench that may inject frames
`timescale 1ns/100ps
`default_nettype none

module fcu_modem
	import fcu_pkg::*;
(
	input  wire fcu_line_out_t line_out,
	input  wire logic          inject,
	input  wire logic          inject_lvl,
	output logic               line_lvl,
	output logic               rxd
);
	// bus level: pull-up holds idle when txd floats
	assign line_lvl = line_out.txd_oe_n ? 1'b1 : line_out.txd_out;
	// receive path: bus echo or a bench-made frame
	assign rxd = inject ? inject_lvl : line_lvl;
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the fieldbus character uart
// assumes the modem model echoes the bus back to the receiver
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import fcu_pkg::*;
	localparam int BITC = 8; // clocks per bit with bit_div 1

	logic          sys_clk, reset_n, sd, sr, cts, flt, inj, inj_lvl;
	logic          tx_ready, tx_busy, rxd, line_lvl;
	fcu_tx_byte_t  tx_byte;
	fcu_rx_byte_t  rx_byte, r;
	fcu_line_out_t line_out;
	int            failures, samples_checked, n;
	logic          got;

	fcu_uart u_fcu_uart (.sys_clk(sys_clk), .reset_n(reset_n),
		.bit_div(16'h0001), .stop_check_disable(sd),
		.start_check_relax(sr), .tx_byte(tx_byte), .tx_ready(tx_ready),
		.tx_busy(tx_busy), .rx_byte(rx_byte), .rxd_pin(rxd),
		.clear_to_send_in(cts), .output_float_test_pin(flt),
		.line_out(line_out));
	fcu_modem u_fcu_modem (.line_out(line_out), .inject(inj),
		.inject_lvl(inj_lvl), .line_lvl(line_lvl), .rxd(rxd));

	// ==========================================
	// clock and helpers
	always #12.5 sys_clk = ~sys_clk;

	task automatic chk_bit(input logic g, input logic e);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_rx(input fcu_rx_byte_t g, input fcu_rx_byte_t e);
		samples_checked++;
		if (g !== e)
		begin
			failures++;
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// wait for one rx pulse, counting clocks
	task automatic wait_rx(input int lim);
		got = 1'b0;
		for (n = 1; n <= lim && !got; n++)
		begin
			@(negedge sys_clk);
			if (rx_byte.valid === 1'b1)
			begin
				got = 1'b1;
				r = rx_byte;
			end
		end
		n--;
	endtask

	// wait for tx_ready, then offer one byte for a single clock
	task automatic send_tx(input logic [7:0] d, input logic l);
		@(negedge sys_clk);
		for (int i = 0; i < 500 && tx_ready !== 1'b1; i++)
			@(negedge sys_clk);
		tx_byte = '{1'b1, l, d};
		@(negedge sys_clk);
		tx_byte.valid = 1'b0;
	endtask

	// bench-made frame on the receive line
	task automatic put_frame(input logic [7:0] d, input logic p,
		input logic s, input int sl);
		logic [10:0] f;
		f = {s, p, d, 1'b0};
		inj = 1'b1;
		for (int i = 0; i < 11; i++)
		begin
			inj_lvl = f[i];
			repeat ((i == 10) ? sl : BITC) @(negedge sys_clk);
		end
		// shortened stop: line pulled low for the rest of the bit
		if (sl < BITC)
		begin
			inj_lvl = 1'b0;
			repeat (BITC - sl) @(negedge sys_clk);
		end
		inj_lvl = 1'b1;
	endtask

	// ==========================================
	// scenarios
	task automatic test_float;
		flt = 1'b0;
		repeat (5) @(negedge sys_clk);
		chk_bit(line_out.rts_oe_n, 1'b1);
		chk_bit(line_out.txd_oe_n, 1'b1);
		flt = 1'b1;
		repeat (5) @(negedge sys_clk);
		chk_bit(line_out.rts_oe_n, 1'b0);
		$display("test_float done");
	endtask

	task automatic test_pair;
		cts = 1'b0;
		send_tx(8'ha5, 1'b0);
		send_tx(8'h3c, 1'b1);
		wait_rx(400);
		chk_rx(r, '{1'b1, 1'b0, 1'b0, 8'ha5});
		wait_rx(400);
		chk_bit(n == 11 * BITC, 1'b1);
		chk_rx(r, '{1'b1, 1'b0, 1'b0, 8'h3c});
		repeat (16) @(negedge sys_clk);
		chk_bit(line_out.rts_out, 1'b0);
		chk_bit(line_lvl, 1'b1);
		$display("test_pair done");
	endtask

	task automatic test_cts;
		cts = 1'b1;
		send_tx(8'h81, 1'b1);
		repeat (100) @(negedge sys_clk);
		chk_bit(line_out.rts_out, 1'b1);
		chk_bit(line_out.txd_oe_n, 1'b1);
		cts = 1'b0;
		wait_rx(400);
		chk_rx(r, '{1'b1, 1'b0, 1'b0, 8'h81});
		$display("test_cts done");
	endtask

	task automatic test_glitch;
		inj = 1'b1;
		inj_lvl = 1'b0;
		repeat (2) @(negedge sys_clk);
		inj_lvl = 1'b1;
		wait_rx(120);
		chk_bit(got, 1'b0);
		fork
			put_frame(8'h5e, 1'b1, 1'b1, BITC);
			wait_rx(200);
		join
		chk_rx(r, '{1'b1, 1'b0, 1'b0, 8'h5e});
		$display("test_glitch done");
	endtask

	task automatic test_errors;
		for (int k = 0; k < 4; k++)
		begin
			sd = (k == 1);
			sr = (k == 3);
			fork
				put_frame(8'h01, k != 2, k >= 2, (k == 3) ? 4 : BITC);
				wait_rx(200);
			join
			chk_rx(r, '{1'b1, k == 2, k == 0, 8'h01});
			repeat (BITC) @(negedge sys_clk);
		end
		sr = 1'b0;
		inj = 1'b0;
		$display("test_errors done");
	endtask

	// ==========================================
	// end of run
	task automatic test_done;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		#(25 * 20000);
		failures++;
		test_done;
	end

	initial
	begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		{sd, sr, cts, inj} = 4'h0;
		{flt, inj_lvl} = 2'h3;
		tx_byte = '0;
		failures = 0;
		samples_checked = 0;
		repeat (12) @(negedge sys_clk);
		reset_n = 1'b1;
		test_float;
		test_pair;
		test_cts;
		test_glitch;
		test_errors;
		test_done;
	end
endmodule
`default_nettype wire
